/* hdl/sfoc_map.vh */
// constants for the serial flash operating control block
`ifndef SFOC_MAP_VH
`define SFOC_MAP_VH

// ***************************************************
// command codes
// ***************************************************
`define SFOC_CMD_LATCH_SET 8'h06
`define SFOC_CMD_LATCH_CLEAR 8'h04
`define SFOC_CMD_STATUS_READ 8'h05
`define SFOC_CMD_STATUS_WRITE 8'h01
`define SFOC_CMD_PAGE_WRITE 8'h02
`define SFOC_CMD_DUAL_WRITE 8'ha2
`define SFOC_CMD_OTP_WRITE 8'h42
`define SFOC_CMD_SUBSECTOR_CLEAR 8'h20
`define SFOC_CMD_SECTOR_CLEAR 8'hd8
`define SFOC_CMD_ARRAY_CLEAR 8'hc7
`define SFOC_CMD_DEEP_SLEEP 8'hb9
`define SFOC_CMD_WAKE 8'hab

// ***************************************************
// status byte layout and reset values
// ***************************************************
`define SFOC_ST_BUSY 0
`define SFOC_ST_LATCH 1
`define SFOC_ST_PROT_LO 2
`define SFOC_ST_PROT_HI 4
`define SFOC_PROT_RESET 3'h0

// ***************************************************
// byte positions within a command
// ***************************************************
`define SFOC_IDX_ADDR_LAST 4'h3
`define SFOC_IDX_DATA 4'h4
`define SFOC_IDX_MAX 4'hf

// ***************************************************
// erase kinds and power modes
// ***************************************************
`define SFOC_ERASE_SUBSECTOR 2'h0
`define SFOC_ERASE_SECTOR 2'h1
`define SFOC_ERASE_ARRAY 2'h2
`define SFOC_PWR_STANDBY 2'h0
`define SFOC_PWR_ACTIVE 2'h1
`define SFOC_PWR_DEEP 2'h2

`endif

/* hdl/sfoc_buffer.v */
// two-entry buffer between the byte receiver and the program port
`default_nettype none

module sfoc_buffer (
  input wire clk_sys,
  input wire reset,
  input wire inValid,
  output reg inReady,
  input wire [32:0] inData,
  output reg outValid,
  input wire outReady,
  output reg [32:0] outData
);

  reg [32:0] spare;
  reg [1:0] fill;
  wire push = inValid & inReady;
  wire pop = outValid & outReady;
  reg [1:0] next_fill;

  // fill level after this cycle's push and pop
  always @* begin
    next_fill = fill;
    if (push & ~pop) begin
      next_fill = fill + 2'h1;
    end else if (pop & ~push) begin
      next_fill = fill - 2'h1;
    end
  end

  // entry one is the output register, so the head never passes a mux
  always @(posedge clk_sys) begin
    if (reset) begin
      fill <= 2'h0;
      inReady <= 1'b1;
      outValid <= 1'b0;
      outData <= 33'h0;
      spare <= 33'h0;
    end else begin
      fill <= next_fill;
      inReady <= (next_fill != 2'h2);
      outValid <= (next_fill != 2'h0);
      if (pop) begin
        if (fill == 2'h2) begin
          outData <= spare;
          if (push) begin
            spare <= inData;
          end
        end else if (push) begin
          outData <= inData;
        end
      end else if (push) begin
        if (fill == 2'h0) begin
          outData <= inData;
        end else begin
          spare <= inData;
        end
      end
    end
  end

endmodule

`default_nettype wire

/* hdl/sfoc_top.v */
// command decoder, write latch, busy and power control of the serial flash
`include "sfoc_map.vh"
`default_nettype none

module sfoc_top (
  input wire clk_sys,
  input wire reset,
  input wire spiClk,
  input wire chipSelectN,
  input wire serialLane0In,
  output reg serialLane0Out,
  output reg serialLane0OutEnN,
  input wire serialLane1In,
  output reg serialLane1Out,
  output reg serialLane1OutEnN,
  input wire writeProtectN,
  input wire cycleDone,
  output wire progValid,
  input wire progReady,
  output wire [23:0] progAddr,
  output wire [7:0] progData,
  output wire progOtp,
  output reg progCommit,
  output reg progAbort,
  output reg progOverrun,
  output reg eraseStart,
  output reg [1:0] eraseKind,
  output reg [23:0] eraseAddr,
  output reg busyFlag,
  output reg writeEnableLatch,
  output reg [2:0] protectSize,
  output reg [1:0] powerMode
);

  // ***************************************************
  // decoding helpers
  // ***************************************************

  // commands whose data bytes go to the program port
  function isProgCmd;
    input [7:0] code;
    begin
      isProgCmd = (code == `SFOC_CMD_PAGE_WRITE) || (code == `SFOC_CMD_DUAL_WRITE) ||
        (code == `SFOC_CMD_OTP_WRITE);
    end
  endfunction

  // ***************************************************
  // pin synchronisers
  // ***************************************************
  wire [4:0] rawPins = {writeProtectN, serialLane1In, serialLane0In, chipSelectN, spiClk};
  reg [4:0] syncA;
  reg [4:0] syncB;

  // two stages per pin; stage A feeds only stage B
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : gSync
      always @(posedge clk_sys) begin
        if (reset) begin
          syncA[gi] <= 1'b0;
          syncB[gi] <= 1'b0;
        end else begin
          syncA[gi] <= rawPins[gi];
          syncB[gi] <= syncA[gi];
        end
      end
    end
  endgenerate

  wire sck = syncB[0];
  wire csN = syncB[1];
  wire lane0 = syncB[2];
  wire lane1 = syncB[3];
  wire wpN = syncB[4];

  // ***************************************************
  // edge detection
  // ***************************************************
  reg sckPrev;
  reg csPrev;
  reg selected;

  // csPrev resets low so a select held low through power-up is no falling edge
  wire csFall = csPrev & ~csN;
  wire csRise = ~csPrev & csN;
  // rising clock is the sampling edge in both modes; idle level is irrelevant
  wire sckRise = ~sckPrev & sck & selected & ~csN;
  wire sckFall = sckPrev & ~sck & selected & ~csN;

  always @(posedge clk_sys) begin
    if (reset) begin
      sckPrev <= 1'b0;
      csPrev <= 1'b0;
    end else begin
      sckPrev <= sck;
      csPrev <= csN;
    end
  end

  // ***************************************************
  // command state
  // ***************************************************
  reg [7:0] cmd;
  reg [7:0] shiftIn;
  reg [2:0] phase;
  reg [3:0] byteIdx;
  reg [23:0] addr;
  reg [7:0] statusIn;
  reg dataSeen;
  reg deepSleep;
  reg [2:0] outBit;
  reg pushValid;
  reg [32:0] pushWord;
  wire bufInReady;
  wire [32:0] bufOut;

  reg [7:0] next_shift;
  reg [3:0] next_phaseSum;
  reg dualPhase;

  // dual-lane data phase takes two bits per clock, lane1 first
  always @* begin
    dualPhase = (cmd == `SFOC_CMD_DUAL_WRITE) && (byteIdx >= `SFOC_IDX_DATA);
    if (dualPhase) begin
      next_shift = {shiftIn[5:0], lane1, lane0};
      next_phaseSum = {1'b0, phase} + 4'h2;
    end else begin
      next_shift = {shiftIn[6:0], lane0};
      next_phaseSum = {1'b0, phase} + 4'h1;
    end
  end

  wire byteDone = next_phaseSum[3];
  wire progAllowed = writeEnableLatch & ~deepSleep & ~busyFlag;
  // alignment counts bits, so a dual-lane byte of four pulses still closes a byte
  wire aligned = (phase == 3'h0);
  wire cmdOk = aligned & ~busyFlag;
  wire [7:0] statusNow = {3'h0, protectSize, writeEnableLatch, busyFlag};

  // ***************************************************
  // main sequencer
  // ***************************************************

  // one process owns all flags so set and clear never race between processes
  always @(posedge clk_sys) begin
    if (reset) begin
      selected <= 1'b0;
      cmd <= 8'h00;
      shiftIn <= 8'h00;
      phase <= 3'h0;
      byteIdx <= 4'h0;
      addr <= 24'h0;
      statusIn <= 8'h00;
      dataSeen <= 1'b0;
      deepSleep <= 1'b0;
      outBit <= 3'h0;
      pushValid <= 1'b0;
      pushWord <= 33'h0;
      busyFlag <= 1'b0;
      writeEnableLatch <= 1'b0;
      protectSize <= `SFOC_PROT_RESET;
      progCommit <= 1'b0;
      progAbort <= 1'b0;
      progOverrun <= 1'b0;
      eraseStart <= 1'b0;
      eraseKind <= `SFOC_ERASE_SUBSECTOR;
      eraseAddr <= 24'h0;
      serialLane0Out <= 1'b0;
      serialLane0OutEnN <= 1'b1;
      serialLane1Out <= 1'b0;
      serialLane1OutEnN <= 1'b1;
    end else begin
      progCommit <= 1'b0;
      progAbort <= 1'b0;
      eraseStart <= 1'b0;
      // the buffer's ready holds the pending byte until it is taken
      if (pushValid && bufInReady) begin
        pushValid <= 1'b0;
      end
      // internal cycle ends: busy and latch drop together
      if (cycleDone && busyFlag) begin
        busyFlag <= 1'b0;
        writeEnableLatch <= 1'b0;
      end
      if (csFall) begin
        // new command frame; only a real falling edge opens one
        selected <= 1'b1;
        cmd <= 8'h00;
        phase <= 3'h0;
        byteIdx <= 4'h0;
        dataSeen <= 1'b0;
        outBit <= 3'h0;
        progOverrun <= 1'b0;
      end else if (csRise && selected) begin
        // deselect ends the frame; anything unfinished is dropped
        selected <= 1'b0;
        serialLane1OutEnN <= 1'b1;
        if (deepSleep) begin
          // only the wake code is heard in deep sleep
          if (cmd == `SFOC_CMD_WAKE) begin
            deepSleep <= 1'b0;
          end
          if (dataSeen) begin
            progAbort <= 1'b1;
          end
        end else begin
          case (cmd)
            `SFOC_CMD_LATCH_SET: begin
              if (cmdOk) begin
                writeEnableLatch <= 1'b1;
              end
            end
            `SFOC_CMD_LATCH_CLEAR: begin
              if (cmdOk) begin
                writeEnableLatch <= 1'b0;
              end
            end
            `SFOC_CMD_DEEP_SLEEP: begin
              if (cmdOk && byteIdx == 4'h1) begin
                deepSleep <= 1'b1;
              end
            end
            `SFOC_CMD_STATUS_WRITE: begin
              if (cmdOk && writeEnableLatch && byteIdx >= 4'h2) begin
                busyFlag <= 1'b1;
                if (wpN) begin
                  protectSize <= statusIn[`SFOC_ST_PROT_HI:`SFOC_ST_PROT_LO];
                end
              end
            end
            `SFOC_CMD_SUBSECTOR_CLEAR, `SFOC_CMD_SECTOR_CLEAR: begin
              if (cmdOk && writeEnableLatch && byteIdx == `SFOC_IDX_DATA) begin
                eraseStart <= 1'b1;
                eraseKind <= (cmd == `SFOC_CMD_SECTOR_CLEAR) ? `SFOC_ERASE_SECTOR : `SFOC_ERASE_SUBSECTOR;
                eraseAddr <= addr;
                busyFlag <= 1'b1;
              end
            end
            `SFOC_CMD_ARRAY_CLEAR: begin
              if (cmdOk && writeEnableLatch && byteIdx == 4'h1) begin
                eraseStart <= 1'b1;
                eraseKind <= `SFOC_ERASE_ARRAY;
                eraseAddr <= 24'h0;
                busyFlag <= 1'b1;
              end
            end
            default: begin
              // program commands commit only whole, aligned frames
              if (isProgCmd(cmd) && dataSeen && cmdOk && writeEnableLatch) begin
                progCommit <= 1'b1;
                busyFlag <= 1'b1;
              end else if (dataSeen) begin
                progAbort <= 1'b1;
              end
            end
          endcase
        end
      end else if (sckRise) begin
        // sample the lanes on the rising edge
        shiftIn <= next_shift;
        phase <= next_phaseSum[2:0];
        if (byteDone) begin
          if (byteIdx != `SFOC_IDX_MAX) begin
            byteIdx <= byteIdx + 4'h1;
          end
          if (byteIdx == 4'h0) begin
            cmd <= next_shift;
          end else if (cmd == `SFOC_CMD_STATUS_WRITE) begin
            if (byteIdx == 4'h1) begin
              statusIn <= next_shift;
            end
          end else if (byteIdx <= `SFOC_IDX_ADDR_LAST) begin
            addr <= {addr[15:0], next_shift};
          end else if (isProgCmd(cmd) && progAllowed) begin
            if (pushValid && !bufInReady) begin
              // a full buffer cannot stall the master, so the byte is flagged lost
              progOverrun <= 1'b1;
            end else begin
              pushValid <= 1'b1;
              pushWord <= {(cmd == `SFOC_CMD_OTP_WRITE), addr, next_shift};
              // column wraps inside the page, so 256 bytes stay on one page
              addr[7:0] <= addr[7:0] + 8'h01;
              dataSeen <= 1'b1;
            end
          end
        end
      end else if (sckFall) begin
        // status read drives lane1 from the falling edge, msb first
        if (cmd == `SFOC_CMD_STATUS_READ && byteIdx != 4'h0 && !deepSleep) begin
          serialLane1OutEnN <= 1'b0;
          serialLane1Out <= statusNow[~outBit];
          outBit <= outBit + 3'h1;
        end
      end
    end
  end

  // ***************************************************
  // power mode
  // ***************************************************

  // outside deep sleep, active while a frame is open or a cycle runs; the open frame avoids a false wake after reset
  always @(posedge clk_sys) begin
    if (reset) begin
      powerMode <= `SFOC_PWR_STANDBY;
    end else if (deepSleep) begin
      powerMode <= `SFOC_PWR_DEEP;
    end else if (selected || busyFlag) begin
      powerMode <= `SFOC_PWR_ACTIVE;
    end else begin
      powerMode <= `SFOC_PWR_STANDBY;
    end
  end

  // ***************************************************
  // program data buffer
  // ***************************************************
  sfoc_buffer uBuffer (
    .clk_sys(clk_sys),
    .reset(reset),
    .inValid(pushValid),
    .inReady(bufInReady),
    .inData(pushWord),
    .outValid(progValid),
    .outReady(progReady),
    .outData(bufOut)
  );

  assign progOtp = bufOut[32];
  assign progAddr = bufOut[31:8];
  assign progData = bufOut[7:0];

endmodule

`default_nettype wire

/* tb/sfoc_assertions.sv */
// port checks of the serial flash control block
`default_nettype none
module sfoc_assertions (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic chipSelectN,
  input wire logic writeProtectN,
  input wire logic cycleDone,
  input wire logic serialLane0OutEnN,
  input wire logic serialLane1OutEnN,
  input wire logic progCommit,
  input wire logic eraseStart,
  input wire logic busyFlag,
  input wire logic writeEnableLatch,
  input wire logic [2:0] protectSize,
  input wire logic [1:0] powerMode
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****
  // properties, six cycles cover the pin synchronisers
  // ****
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  frozen_protect_a: assert property ((!writeProtectN)[*6] |=> $stable(protectSize))
    else $error("protect size moved while frozen");
  lanes_released_a: assert property (chipSelectN[*6] |-> serialLane1OutEnN && serialLane0OutEnN)
    else $error("lane driven while deselected");
  start_latch_a: assert property (eraseStart || progCommit |-> writeEnableLatch)
    else $error("write started without latch");
  start_busy_a: assert property (eraseStart || progCommit |-> ##[0:1] busyFlag)
    else $error("busy flag missing after start");
  select_active_a: assert property ((!chipSelectN)[*6] ##0 powerMode != 2'h2 |-> powerMode == 2'h1)
    else $error("selected but not active");
  busy_active_a: assert property (busyFlag && $past(busyFlag) |-> powerMode == 2'h1)
    else $error("left active during cycle");
  deep_quiet_a: assert property (powerMode == 2'h2 |-> !eraseStart && !progCommit && !$rose(writeEnableLatch))
    else $error("write acted in deep sleep");
  done_latch_a: assert property (busyFlag && cycleDone |=> !writeEnableLatch && !busyFlag)
    else $error("cycle end left latch or busy");
  idle_standby_a: assert property ((chipSelectN && !busyFlag)[*8] ##0 powerMode != 2'h2 |-> powerMode == 2'h0)
    else $error("idle but not standby");
endmodule
`default_nettype wire

/* tb/sfoc_spi_master.sv */
// serial bus master model driving the flash link
`default_nettype none
module sfoc_spi_master (
  output logic spiClk,
  output logic chipSelectN,
  output logic lane0,
  output logic lane1,
  input wire logic miso
);
  timeunit 1ns;
  timeprecision 100ps;
  logic cpol = 1'b0;
  logic [7:0] rx = 8'h00;
  // ****
  // frame engine
  // ****
  initial begin
    spiClk = 1'b0;
    chipSelectN = 1'b1;
    lane0 = 1'b0;
    lane1 = 1'b1;
  end
  // msb first; bits from dualAt on go two per clock
  task automatic frame(input logic [63:0] b, input int n, input int dualAt);
    int i;
    i = 0;
    spiClk = cpol; // park level by mode
    #62.5;
    chipSelectN = 1'b0; // select falls before each command
    #62.5;
    while (i < n) begin
      spiClk = 1'b0; // data changes after the fall
      if (i >= dualAt) begin
        lane1 = b[63-i];
        lane0 = b[62-i];
        i = i + 2;
      end else begin
        lane0 = b[63-i];
        i = i + 1;
      end
      #62.5;
      spiClk = 1'b1;
      rx = {rx[6:0], miso}; // sampled on the rise
      #62.5;
    end
    spiClk = cpol;
    #62.5;
    chipSelectN = 1'b1; // only this device on the bus
    lane0 = ~lane0; // released lines must not keep the old value
    lane1 = ~lane1;
    #250;
  endtask
endmodule
`default_nettype wire

/* tb/tb.sv */
// top testbench of the serial flash control block
`include "sfoc_map.vh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  // ****
  // pins, back end and counters
  // ****
  logic clk_sys = 1'b0, reset = 1'b1, writeProtectN = 1'b1, cycleDone = 1'b0, progReady = 1'b0, hold = 1'b0;
  logic [2:0] stall = 3'h0;
  wire logic spiClk, chipSelectN, lane0, lane1, lane0Wire, lane1Wire;
  wire logic serialLane0Out, serialLane0OutEnN, serialLane1Out, serialLane1OutEnN, progValid, progOtp;
  wire logic progCommit, progAbort, progOverrun, eraseStart, busyFlag, writeEnableLatch;
  wire logic [23:0] progAddr, eraseAddr;
  wire logic [7:0] progData;
  wire logic [2:0] protectSize;
  wire logic [1:0] eraseKind, powerMode;
  int errorCnt = 0, checkCount = 0, nCommit = 0, nAbort = 0, nErase = 0;
  logic [32:0] words[$];
  assign lane0Wire = serialLane0OutEnN ? lane0 : serialLane0Out;
  assign lane1Wire = serialLane1OutEnN ? lane1 : serialLane1Out;
  sfoc_spi_master sfoc_spi_master_i (.spiClk(spiClk), .chipSelectN(chipSelectN), .lane0(lane0),
    .lane1(lane1), .miso(lane1Wire));
  sfoc_top sfoc_top_i (.clk_sys(clk_sys), .reset(reset), .spiClk(spiClk), .chipSelectN(chipSelectN),
    .serialLane0In(lane0Wire), .serialLane0Out(serialLane0Out), .serialLane0OutEnN(serialLane0OutEnN),
    .serialLane1In(lane1Wire), .serialLane1Out(serialLane1Out), .serialLane1OutEnN(serialLane1OutEnN),
    .writeProtectN(writeProtectN), .cycleDone(cycleDone), .progValid(progValid), .progReady(progReady),
    .progAddr(progAddr), .progData(progData), .progOtp(progOtp), .progCommit(progCommit),
    .progAbort(progAbort), .progOverrun(progOverrun), .eraseStart(eraseStart), .eraseKind(eraseKind),
    .eraseAddr(eraseAddr), .busyFlag(busyFlag), .writeEnableLatch(writeEnableLatch),
    .protectSize(protectSize), .powerMode(powerMode));
  always #5 clk_sys = ~clk_sys;
  // back end ready only half the time, so the buffer has to hold words
  always @(posedge clk_sys) begin
    stall <= stall + 3'h1;
    progReady <= stall[1] && !hold;
    if (progValid && progReady) words.push_back({progOtp, progAddr, progData});
    if (progCommit) nCommit++;
    if (progAbort) nAbort++;
    if (eraseStart) nErase++;
  end
  // ****
  // shared tasks
  // ****
  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    checkCount++;
    if (got !== exp) begin
      errorCnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic endSim;
    $display("checks %0d errors %0d", checkCount, errorCnt);
    if (errorCnt == 0 && checkCount > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic send(input logic [63:0] b, input int n, input int d = 64);
    sfoc_spi_master_i.frame(b, n, d);
    repeat (2) @(negedge clk_sys);
  endtask
  task automatic latch;
    send({`SFOC_CMD_LATCH_SET, 56'h0}, 8);
  endtask
  task automatic done;
    @(posedge clk_sys) cycleDone <= 1'b1;
    @(posedge clk_sys) cycleDone <= 1'b0;
    repeat (3) @(negedge clk_sys);
  endtask
  // ****
  // scenarios
  // ****
  task automatic tReset;
    check(writeEnableLatch, 0);
    check({busyFlag, protectSize, powerMode}, 0);
    check({serialLane0OutEnN, serialLane1OutEnN}, 2'h3);
    check({serialLane0Out, serialLane1Out}, 2'h0);
  endtask
  task automatic tStatusMode1;
    sfoc_spi_master_i.cpol = 1'b1;
    latch();
    send({`SFOC_CMD_STATUS_READ, 56'h0}, 16);
    check(sfoc_spi_master_i.rx, 8'h02);
    sfoc_spi_master_i.cpol = 1'b0;
    send({`SFOC_CMD_LATCH_CLEAR, 56'h0}, 8);
    check(writeEnableLatch, 0);
  endtask
  task automatic tPages;
    words = {};
    nCommit = 0;
    latch();
    send({`SFOC_CMD_PAGE_WRITE, 24'h0012ff, 16'h5ac3, 16'h0}, 48);
    check(nCommit, 1);
    check(powerMode, `SFOC_PWR_ACTIVE);
    check(words[0], 32'h0012ff5a);
    check(words[1], 32'h001200c3);
    done();
    check({busyFlag, writeEnableLatch, powerMode}, 0);
    latch();
    send({`SFOC_CMD_DUAL_WRITE, 24'h000040, 8'h96, 24'h0}, 40, 32);
    check(nCommit, 2);
    check(words[2], 32'h00004096);
    done();
    latch();
    send({`SFOC_CMD_OTP_WRITE, 24'h000007, 8'h3c, 24'h0}, 40);
    check(busyFlag, 1);
    check(words[3], 33'h10000073c);
    done();
  endtask
  task automatic tBadFrames;
    nAbort = 0;
    nCommit = 0;
    latch();
    send({`SFOC_CMD_PAGE_WRITE, 24'h0, 12'hfff, 20'h0}, 44);
    check({nAbort[3:0], nCommit[3:0], busyFlag}, 9'h020);
    @(posedge clk_sys) hold <= 1'b1;
    send({`SFOC_CMD_PAGE_WRITE, 24'h000100, 32'h01020304}, 64);
    check(progOverrun, 1);
    @(posedge clk_sys) hold <= 1'b0;
    done();
  endtask
  task automatic tErase;
    logic [7:0] op[3] = '{`SFOC_CMD_SUBSECTOR_CLEAR, `SFOC_CMD_SECTOR_CLEAR, `SFOC_CMD_ARRAY_CLEAR};
    for (int k = 0; k < 3; k++) begin
      nErase = 0;
      latch();
      send({op[k], 24'h012345, 32'h0}, k == 2 ? 8 : 32);
      check({nErase[1:0], eraseKind, busyFlag}, {2'h1, k[1:0], 1'b1});
      if (k < 2) check(eraseAddr, 24'h012345);
      done();
    end
    nErase = 0;
    send({`SFOC_CMD_SECTOR_CLEAR, 56'h0}, 32);
    latch();
    send({`SFOC_CMD_SECTOR_CLEAR, 56'h0}, 36);
    check(nErase, 0);
    send({`SFOC_CMD_LATCH_CLEAR, 56'h0}, 8);
  endtask
  task automatic tDeep;
    send({`SFOC_CMD_DEEP_SLEEP, 56'h0}, 8);
    check(powerMode, `SFOC_PWR_DEEP);
    latch();
    check({writeEnableLatch, powerMode}, {1'b0, `SFOC_PWR_DEEP});
    send({`SFOC_CMD_WAKE, 56'h0}, 8);
    check(powerMode, `SFOC_PWR_STANDBY);
  endtask
  task automatic tProtect;
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_sys) writeProtectN <= (k == 1);
      latch();
      send({`SFOC_CMD_STATUS_WRITE, 8'h1c, 48'h0}, 16);
      check(busyFlag, 1);
      done();
      check(protectSize, k == 1 ? 3'h7 : 3'h0);
    end
    send({`SFOC_CMD_STATUS_READ, 56'h0}, 16);
    check(sfoc_spi_master_i.rx, 8'h1c);
  endtask
  // main sequence and watchdog
  initial begin
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (6) @(negedge clk_sys);
    tReset();
    tStatusMode1();
    tPages();
    tBadFrames();
    tErase();
    tDeep();
    tProtect();
    endSim();
  end
  initial begin
    #200000;
    errorCnt++;
    endSim();
  end
endmodule
bind sfoc_top sfoc_assertions chk_i (.clk_sys(clk_sys), .reset(reset), .chipSelectN(chipSelectN),
  .writeProtectN(writeProtectN), .cycleDone(cycleDone), .serialLane0OutEnN(serialLane0OutEnN),
  .serialLane1OutEnN(serialLane1OutEnN), .progCommit(progCommit), .eraseStart(eraseStart),
  .busyFlag(busyFlag), .writeEnableLatch(writeEnableLatch), .protectSize(protectSize), .powerMode(powerMode));
`default_nettype wire
